// >>> verilog/digipot_pkg.sv
// Shared constants for the serial command engine of the digital potentiometer
package digipot_pkg;
  localparam int FRAME_BITS = 24;
  localparam int CNT_W = 5;
  localparam logic [4:0] FRAME_LEN = 5'h18;
  localparam logic [4:0] CNT_MAX = 5'h1F;
  localparam int WIPER_W = 10;
  localparam logic [9:0] WIPER_MAX = 10'h3FF;
  localparam int WORD_W = 16;
  localparam int NV_WORDS = 16;
  localparam int ADDR_W = 4;
  localparam int USER_WORDS = 14;
  // Frame field positions
  localparam int CMD_MSB = 23;
  localparam int CMD_LSB = 20;
  localparam int ADR_MSB = 19;
  localparam int ADR_LSB = 16;
  // Fixed nonvolatile locations
  localparam logic [3:0] NV_WIPER = 4'h0;
  localparam logic [3:0] NV_AUX = 4'h1;
  localparam logic [3:0] NV_USER_FIRST = 4'h2;
  // Aux bit positions inside the aux word
  localparam int AUX_ONE_BIT = 0;
  localparam int AUX_TWO_BIT = 1;
  // Factory contents of the store after power-up reset
  localparam logic [15:0] NV_RESET_WORD = 16'h0000;
  localparam logic [15:0] NV_RESET_WIPER = 16'h0200;
  typedef enum logic [3:0] {
    cmd_nop = 4'h0,
    cmd_restore_wiper = 4'h1,
    cmd_store_wiper = 4'h2,
    cmd_store_user = 4'h3,
    cmd_read_mem = 4'h9,
    cmd_read_wiper = 4'hA,
    cmd_write_wiper = 4'hB,
    cmd_shift_left = 4'hC,
    cmd_increment = 4'hE
  } cmd_t;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_shift = 2'b01,
    st_exec = 2'b10
  } frame_state_t;
endpackage

// >>> verilog/nonvolatile_word_store.sv
// Word-wide nonvolatile array with one write port and one read port
`timescale 1ns/1ps
module nonvolatile_word_store
#(
  parameter int WORDS = digipot_pkg::NV_WORDS,
  parameter int WIDTH = digipot_pkg::WORD_W
)
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [3:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  import digipot_pkg::*;

  logic [WIDTH-1:0] mem [WORDS];
  logic [WIDTH-1:0] next_mem [WORDS];

  // Elaboration guard: the 4-bit address nibble reaches exactly this store
  if (WORDS != NV_WORDS || WIDTH != WORD_W)
  begin
    $error("store geometry must match the 4-bit address nibble");
  end

  // Read is combinational so a restore settles in one edge
  assign rd_data = mem[rd_addr];

  // Next contents: only the addressed word changes
  always_comb
  begin
    for (int i = 0; i < WORDS; i++)
      next_mem[i] = mem[i];
    if (wr_en)
      next_mem[wr_addr] = wr_data;
  end

  // Reset stands in for factory contents; real cells keep data
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < WORDS; i++)
        mem[i] <= (i == 0) ? NV_RESET_WIPER : NV_RESET_WORD;
    end
    else
    begin
      for (int i = 0; i < WORDS; i++)
        mem[i] <= next_mem[i];
    end
  end
endmodule

// >>> verilog/digipot_serial_command_engine.sv
// Serial frame decoder driving the wiper code and nonvolatile words
`timescale 1ns/1ps
// Notes on behaviour
// - Write-wiper loads the 10-bit data field into the wiper code.
// - Increment adds one to the wiper code, holding at full scale; data bits ignored.
// - Store-wiper copies the wiper code into nonvolatile word zero.
// - Restore command reloads the wiper code from the word named by the address field.
// - Power-on and restore strobe also reload the wiper from word zero.
// - Left shift doubles the wiper code, a six decibel step up, saturating at full scale from midscale upward.
// - Store-user-data writes 16 data bits to the addressed word.
// - Fourteen user words of sixteen bits each are addressable.
// - Read-memory prepares the addressed word for the next frame.
// - Next frame shifts out command, address and sixteen data bits.
// - No-operation frame returns to idle power, changing no register.
// - Write-protect low blocks every nonvolatile store.
// - Wiper code is 10 bits selecting one of 1024 positions.
// - User words restore into a readable register by read-memory.
// - Restore command leaves read-mode power until a no-operation.
module digipot_serial_command_engine
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic sdi,
  input wire logic wp_n,
  input wire logic restore_strobe_input_n,
  output logic sdo,
  output logic [digipot_pkg::WIPER_W-1:0] wiper_code_register,
  output logic aux_output_bit_one,
  output logic aux_output_bit_two,
  output logic read_mode_power
);
  import digipot_pkg::*;

  // Pin synchronisers: stage one feeds only stage two
  logic [1:0] sclk_sync, sel_sync, sdi_sync, prs_sync, wp_sync;
  logic sclk_d, sel_d, prs_d;
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sclk_sync <= 2'h0;
      sel_sync <= 2'h3;
      sdi_sync <= 2'h0;
      prs_sync <= 2'h3;
      wp_sync <= 2'h0; // Protected until the pin is seen
      sclk_d <= 1'b0;
      sel_d <= 1'b1;
      prs_d <= 1'b1;
    end
    else
    begin
      sclk_sync <= {sclk_sync[0], sclk};
      sel_sync <= {sel_sync[0], sel_n};
      sdi_sync <= {sdi_sync[0], sdi};
      prs_sync <= {prs_sync[0], restore_strobe_input_n};
      wp_sync <= {wp_sync[0], wp_n};
      sclk_d <= sclk_sync[1];
      sel_d <= sel_sync[1];
      prs_d <= prs_sync[1];
    end
  end

  logic sclk_rise, sclk_fall, sel_fall, sel_rise, strobe_fall;
  assign sclk_rise = sclk_sync[1] & ~sclk_d;
  assign sclk_fall = ~sclk_sync[1] & sclk_d;
  assign sel_fall = ~sel_sync[1] & sel_d;
  assign sel_rise = sel_sync[1] & ~sel_d;
  assign strobe_fall = ~prs_sync[1] & prs_d;

  // Frame and command state
  frame_state_t state, next_state;
  logic [CNT_W-1:0] bit_cnt, next_bit_cnt;
  logic [FRAME_BITS-1:0] in_shift, next_in_shift;
  logic [FRAME_BITS-1:0] out_shift, next_out_shift;
  logic [WIPER_W-1:0] next_wiper;
  logic [WORD_W-1:0] readback, next_readback;
  logic next_sdo, next_aux_one, next_aux_two, next_read_mode;
  logic power_up, next_power_up;
  logic power_up_wiper, next_power_up_wiper;
  logic [FRAME_BITS-1:0] echo_word, next_echo_word;
  logic nv_we;
  logic [ADDR_W-1:0] nv_waddr, nv_raddr;
  logic [WORD_W-1:0] nv_wdata, nv_rdata;

  nonvolatile_word_store store_inst (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .wr_en(nv_we),
    .wr_addr(nv_waddr),
    .wr_data(nv_wdata),
    .rd_addr(nv_raddr),
    .rd_data(nv_rdata)
  );

  logic [3:0] f_cmd, f_adr;
  logic [WIPER_W:0] inc_sum;
  assign f_cmd = in_shift[CMD_MSB:CMD_LSB];
  assign f_adr = in_shift[ADR_MSB:ADR_LSB];
  assign inc_sum = {1'b0, wiper_code_register} + 11'h001;

  // Next-state logic for framing, decode and serial output
  always_comb
  begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_in_shift = in_shift;
    next_out_shift = out_shift;
    next_sdo = sdo;
    next_wiper = wiper_code_register;
    next_readback = readback;
    next_aux_one = aux_output_bit_one;
    next_aux_two = aux_output_bit_two;
    next_read_mode = read_mode_power;
    next_power_up = 1'b0;
    next_power_up_wiper = 1'b0;
    next_echo_word = echo_word;
    nv_we = 1'b0;
    nv_waddr = NV_WIPER;
    nv_wdata = {{(WORD_W-WIPER_W){1'b0}}, wiper_code_register};
    nv_raddr = NV_WIPER;
    case (state)
      st_idle:
      begin
        if (sel_fall)
        begin
          next_state = st_shift;
          next_bit_cnt = '0;
          // Shift a copy so a dropped frame leaves the echo intact
          next_out_shift = echo_word;
          next_sdo = echo_word[FRAME_BITS-1];
        end
      end
      st_shift:
      begin
        // Count saturates so an overlong frame is still rejected
        if (sclk_rise)
        begin
          next_in_shift = {in_shift[FRAME_BITS-2:0], sdi_sync[1]};
          if (bit_cnt != CNT_MAX)
            next_bit_cnt = bit_cnt + 5'h01;
        end
        if (sclk_fall)
        begin
          next_out_shift = {out_shift[FRAME_BITS-2:0], 1'b0};
          next_sdo = out_shift[FRAME_BITS-2];
        end
        if (sel_rise)
          next_state = (bit_cnt == FRAME_LEN) ? st_exec : st_idle;
      end
      st_exec:
      begin
        next_state = st_idle;
        next_echo_word = in_shift;
        nv_raddr = f_adr;
        case (f_cmd)
          cmd_nop:
            next_read_mode = 1'b0;
          cmd_restore_wiper:
          begin
            next_wiper = nv_rdata[WIPER_W-1:0];
            next_read_mode = 1'b1;
          end
          cmd_store_wiper:
            nv_we = wp_sync[1];
          cmd_store_user:
          begin
            nv_we = wp_sync[1];
            nv_waddr = f_adr;
            nv_wdata = in_shift[WORD_W-1:0];
          end
          cmd_read_mem:
          begin
            next_readback = nv_rdata;
            next_echo_word = {f_cmd, f_adr, nv_rdata};
            next_read_mode = 1'b1;
          end
          cmd_read_wiper:
            next_echo_word = {f_cmd, f_adr,
              {(WORD_W-WIPER_W){1'b0}}, wiper_code_register};
          cmd_write_wiper:
            next_wiper = in_shift[WIPER_W-1:0];
          cmd_shift_left:
            // Saturate: doubling midscale lands on full scale
            next_wiper = wiper_code_register[WIPER_W-1] ? WIPER_MAX :
              {wiper_code_register[WIPER_W-2:0], 1'b0};
          cmd_increment:
            next_wiper = inc_sum[WIPER_W] ? WIPER_MAX :
              inc_sum[WIPER_W-1:0];
          default:
            next_wiper = wiper_code_register;
        endcase
      end
      default:
        next_state = st_idle;
    endcase
    // Power-up takes two steps since the store has one read port
    if (power_up)
    begin
      nv_raddr = NV_AUX;
      next_aux_one = nv_rdata[AUX_ONE_BIT];
      next_aux_two = nv_rdata[AUX_TWO_BIT];
      next_wiper = wiper_code_register;
      next_power_up_wiper = 1'b1;
    end
    else if (power_up_wiper || strobe_fall)
    begin
      // Strobe shares the port; the first power-up step ignores it
      nv_raddr = NV_WIPER;
      next_wiper = nv_rdata[WIPER_W-1:0];
    end
  end

  // Frame, wiper and power-up registers
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= st_idle;
      bit_cnt <= '0;
      in_shift <= '0;
      out_shift <= '0;
      sdo <= 1'b0;
      wiper_code_register <= '0;
      readback <= '0;
      aux_output_bit_one <= 1'b0;
      aux_output_bit_two <= 1'b0;
      read_mode_power <= 1'b0;
      power_up <= 1'b1;
      power_up_wiper <= 1'b0;
      echo_word <= '0;
    end
    else
    begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      in_shift <= next_in_shift;
      out_shift <= next_out_shift;
      sdo <= next_sdo;
      readback <= next_readback;
      aux_output_bit_one <= next_aux_one;
      aux_output_bit_two <= next_aux_two;
      read_mode_power <= next_read_mode;
      power_up <= next_power_up;
      power_up_wiper <= next_power_up_wiper;
      echo_word <= next_echo_word;
      wiper_code_register <= next_wiper;
    end
  end
endmodule

// >>> test/serial_host.sv
// Serial host model shifting command frames in and out
`timescale 1ns/1ps
module serial_host
(
  input wire logic ref_clk,
  input wire logic sdo,
  output logic sclk,
  output logic sel_n,
  output logic sdi
);
  // Link idle: select high, clock parked low
  initial
  begin
    sclk = 1'b0;
    sel_n = 1'b1;
    sdi = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // n bits MSB first; half periods of 4 cycles clear the 3-cycle minimum
  task automatic frame(input logic [23:0] w, input int n,
    output logic [23:0] r);
    sel_n = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      sdi = w[23 - i];
      wt(4);
      r = {r[22:0], sdo};
      sclk = 1'b1;
      wt(4);
      sclk = 1'b0;
    end
    wt(4);
    sel_n = 1'b1;
    sdi = ~sdi; // No stale data once released
    wt(10);
  endtask
endmodule

// >>> test/digipot_assertions.sv
// Port checks for the serial command engine
`timescale 1ns/1ps
module digipot_checker
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic sdi,
  input wire logic wp_n,
  input wire logic restore_strobe_input_n,
  input wire logic sdo,
  input wire logic [digipot_pkg::WIPER_W-1:0] wiper_code_register,
  input wire logic aux_output_bit_one,
  input wire logic aux_output_bit_two,
  input wire logic read_mode_power
);
  import digipot_pkg::*;
  logic [3:0] t_sel, t_pr, t_rst;
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  // Cycles since each cause of change, saturating at 15
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
    begin
      t_sel <= 4'hF;
      t_pr <= 4'hF;
      t_rst <= 4'h0;
    end
    else
    begin
      t_sel <= $rose(sel_n) ? 4'h0 : t_sel + {3'h0, t_sel != 4'hF};
      t_pr <= $fell(restore_strobe_input_n) ? 4'h0
        : t_pr + {3'h0, t_pr != 4'hF};
      t_rst <= t_rst + {3'h0, t_rst != 4'hF};
    end
  sequence booted;
    $rose(nrst);
  endsequence
  sequence sclk_high;
    sclk [*3];
  endsequence
  boot_load_a: assert property (booted |-> ##[1:4]
    wiper_code_register == NV_RESET_WIPER[9:0]) else $error("boot");
  aux_boot_a: assert property (booted |-> ##3
    {aux_output_bit_two, aux_output_bit_one} == NV_RESET_WORD[1:0])
    else $error("aux boot");
  idle_boot_a: assert property (booted |-> !read_mode_power [*4])
    else $error("mode boot");
  wiper_cause_a: assert property ($changed(wiper_code_register) |->
    t_sel < 4'h9 || t_pr < 4'h9 || t_rst < 4'h9) else $error("wiper");
  mode_cause_a: assert property ($changed(read_mode_power) |->
    t_sel < 4'h9) else $error("mode");
  aux_cause_a: assert property ($changed(aux_output_bit_one) |->
    t_sel < 4'h9 || t_rst < 4'h9) else $error("aux");
  sdo_hold_a: assert property (sclk_high |-> $stable(sdo))
    else $error("sdo");
  strobe_mode_a: assert property ($fell(restore_strobe_input_n)
    && t_sel > 4'hC |=> $stable(read_mode_power) [*6]) else $error("pr");
endmodule
bind digipot_serial_command_engine digipot_checker u_check (.ref_clk,
  .nrst, .sclk, .sel_n, .sdi, .wp_n, .restore_strobe_input_n, .sdo,
  .wiper_code_register, .aux_output_bit_one, .aux_output_bit_two,
  .read_mode_power);

// >>> test/tb.sv
// Self-checking bench for the serial command engine
`timescale 1ns/1ps
module tb;
  import digipot_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic wp_n = 1'b1;
  logic restore_strobe_input_n = 1'b1;
  logic sclk, sel_n, sdi, sdo, aux_output_bit_one, aux_output_bit_two;
  logic read_mode_power, rmode, have;
  logic [WIPER_W-1:0] wiper_code_register;
  logic [9:0] wip;
  logic [15:0] v;
  logic [15:0] nv [16];
  logic [23:0] last, rx;
  logic [31:0] seed = 32'h8C86;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;
  always #50 ref_clk = ~ref_clk;
  serial_host host (.ref_clk, .sdo, .sclk, .sel_n, .sdi);
  digipot_serial_command_engine DUT (.ref_clk, .nrst, .sclk, .sel_n,
    .sdi, .wp_n, .restore_strobe_input_n, .sdo, .wiper_code_register,
    .aux_output_bit_one, .aux_output_bit_two, .read_mode_power);
  // Fixed-seed shift register keeps runs repeatable
  function automatic logic [15:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[15:0];
  endfunction
  function automatic logic [23:0] echo_of(input logic [23:0] w);
    if (w[23:20] == cmd_read_mem)
      return {w[23:16], nv[w[19:16]]};
    if (w[23:20] == cmd_read_wiper)
      return {w[23:16], 6'h00, wip};
    return w;
  endfunction
  // Expected state after a whole frame; saturates at full scale
  task automatic model(input logic [23:0] w);
    case (w[23:20])
      cmd_nop: rmode = 1'b0;
      cmd_restore_wiper:
      begin
        wip = nv[0][9:0];
        rmode = 1'b1;
      end
      cmd_store_wiper: if (wp_n) nv[0] = {6'h00, wip};
      cmd_store_user: if (wp_n) nv[w[19:16]] = w[15:0];
      cmd_read_mem: rmode = 1'b1;
      cmd_write_wiper: wip = w[9:0];
      cmd_shift_left: wip = wip[9] ? WIPER_MAX : {wip[8:0], 1'b0};
      cmd_increment: wip = (wip == WIPER_MAX) ? wip : wip + 10'h001;
      default: ;
    endcase
  endtask
  task automatic cmp_word(input logic [23:0] g, e);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR %0t sdo %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_state(input logic [12:0] g, e);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR %0t state %h exp %h", $time, g, e);
    end
  endtask
  task automatic send(input logic [23:0] w, input int n = 24);
    host.frame(w, n, rx);
    if (n == FRAME_BITS)
    begin
      if (have)
        cmp_word(rx, last);
      last = echo_of(w);
      have = 1'b1;
      model(w);
    end
    cmp_state({aux_output_bit_two, aux_output_bit_one, read_mode_power,
      wiper_code_register}, {nv[1][1:0], rmode, wip});
  endtask
  task automatic end_of_test();
    if (miscompares == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard, well above the expected run length
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      miscompares++;
      end_of_test();
    end
  end
  initial
  begin
    for (int i = 0; i < 16; i++)
      nv[i] = NV_RESET_WORD;
    nv[0] = NV_RESET_WIPER;
    {wip, rmode, have} = 12'h000;
    repeat (20) @(negedge ref_clk);
    nrst = 1'b1;
    repeat (4) @(negedge ref_clk);
    wip = NV_RESET_WIPER[9:0];
    send(24'h000000);
    send(24'hB00100);
    repeat (2) send({8'hE0, rnd()});
    send({8'h20, rnd()});
    v = rnd();
    send({8'hB0, 7'h00, v[8:0]});
    send({8'hC0, rnd()});
    send({8'h10, rnd()});
    send(24'h000000);
    send(24'hB00200);
    send(24'hC00000);
    send(24'hA00000);
    for (int a = 2; a < 16; a++)
      send({4'h3, a[3:0], rnd()});
    for (int a = 2; a < 16; a++)
      send({4'h9, a[3:0], rnd()});
    send(24'h000000);
    wp_n = 1'b0;
    send({8'h3A, rnd()});
    send({8'hB0, 6'h00, v[9:0]});
    send(24'h200000);
    send(24'h9A0000);
    send(24'h100000);
    wp_n = 1'b1;
    send({8'hB0, 6'h00, ~v[9:0]}, 23);
    send(24'h000000);
    send({8'hB0, 6'h00, ~v[9:0]});
    repeat (6) @(negedge ref_clk);
    restore_strobe_input_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    restore_strobe_input_n = 1'b1;
    repeat (10) @(negedge ref_clk);
    wip = nv[0][9:0];
    send(24'h000000);
    end_of_test();
  end
endmodule
